/* File: verilog/swl_cfg.sv */
// Switch link debug, status and configuration registers behind an APB slave.
//
// Functional notes
// - Per tile, bit 1 lets the shared halt line request debug of that core.
// - Per tile, bit 0 lets the core halted flag drive the shared halt line.
// - Halt origin record bit 4 marks the external debug pin as last source.
// - Halt origin record bits 1 and 0 mark core 1 and core 0 as source.
// - Link status bits 25:24 give source-target kind: switch, processor, control, undefined.
// - While a link is in use, bits 23:16 give its destination link number.
// - External links hold a writable four-bit direction field, reset zero.
// - Every link holds a writable two-bit network field, reset zero.
// - Read-only bit 2 shows the current packet is junk and discarded.
// - Bit 1 shows destination side in use, bit 0 source side in use.
// - Processor link status words match external ones but lack the direction field.
// - Setup bit 31 enables or disables the external link and its pin muxing.
// - Setup bit 30 picks two-wire (0) or five-wire (1) mode; both ends agree.
// - Read-only bit 27 shows receive overflow or an illegally encoded token.
// - Bit 26 shows credit issued, bit 25 credit held; no send without credit.
// - Writing one to bit 24 clears local credit and sends a credit request token.
// - Writing one to bit 23 resets the receiver to expect a token start.
// - At least symbol gap plus one idle cycles separate symbols within a token.
// - At least token gap plus one idle cycles separate consecutive tokens.
// - Fixed forwarding sends all received traffic to one channel end, reset disabled.
// - Fixed forwarding bit 8 picks the processor, bits 4:0 the channel end.
// - The eight forwarding words serve links C, D, A, B, G, H, E, F in order.
//
// Implementation choice: register access over APB.
`include "swl_cfg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module swl_cfg #(
	parameter int NLINK = 8
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Debug line.
	input wire logic ext_halt_pin_n_in,
	input wire logic [1:0] core_halted_flag_in,
	output logic shared_halt_line_out,
	output logic [1:0] core_debug_req_out,
	// Switch link status from the routing fabric.
	input wire logic [NLINK-1:0][1:0] link_kind_in,
	input wire logic [NLINK-1:0][7:0] link_dest_in,
	input wire logic [NLINK-1:0] link_junk_in,
	input wire logic [NLINK-1:0] link_dst_use_in,
	input wire logic [NLINK-1:0] link_src_use_in,
	output logic [NLINK-1:0][3:0] link_dir_out,
	output logic [NLINK-1:0][1:0] link_net_out,
	// Processor link status from the routing fabric.
	input wire logic [NLINK-1:0][1:0] processor_link_kind_in,
	input wire logic [NLINK-1:0][7:0] processor_link_dest_in,
	input wire logic [NLINK-1:0] processor_link_junk_in,
	input wire logic [NLINK-1:0] processor_link_dst_use_in,
	input wire logic [NLINK-1:0] processor_link_src_use_in,
	output logic [NLINK-1:0][1:0] processor_link_net_out,
	// External link ends.
	input wire logic [NLINK-1:0] rx_error_in,
	input wire logic [NLINK-1:0] credit_issued_in,
	input wire logic [NLINK-1:0] credit_rx_in,
	input wire logic [NLINK-1:0] tx_symbol_in,
	input wire logic [NLINK-1:0] tx_token_end_in,
	output logic [NLINK-1:0] link_enable_out,
	output logic [NLINK-1:0] link_wide_out,
	output logic [NLINK-1:0] credit_request_token_out,
	output logic [NLINK-1:0] rx_reset_out,
	output logic [NLINK-1:0] tx_ready_out,
	// Fixed forwarding, indexed by link number.
	output logic [NLINK-1:0] fwd_enable_out,
	output logic [NLINK-1:0] fwd_proc_out,
	output logic [NLINK-1:0][4:0] fwd_chan_out
);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------

	// Returns the register group that a word index falls in.
	function automatic swl_cfg_pkg::swl_region_t region_of(input logic [`SWL_IDX_W-1:0] idx);
		region_of = swl_cfg_pkg::RG_NONE;
		if (idx == `SWL_IDX_DBG0) begin
			region_of = swl_cfg_pkg::RG_DBG0;
		end else if (idx == `SWL_IDX_DBG1) begin
			region_of = swl_cfg_pkg::RG_DBG1;
		end else if (idx == `SWL_IDX_ORIGIN) begin
			region_of = swl_cfg_pkg::RG_ORIGIN;
		end else if (idx >= `SWL_IDX_LSTAT && idx < `SWL_IDX_LSTAT + `SWL_GROUP_LEN) begin
			region_of = swl_cfg_pkg::RG_LSTAT;
		end else if (idx >= `SWL_IDX_PSTAT && idx < `SWL_IDX_PSTAT + `SWL_GROUP_LEN) begin
			region_of = swl_cfg_pkg::RG_PSTAT;
		end else if (idx >= `SWL_IDX_LCFG && idx < `SWL_IDX_LCFG + `SWL_GROUP_LEN) begin
			region_of = swl_cfg_pkg::RG_LCFG;
		end else if (idx >= `SWL_IDX_FWD && idx < `SWL_IDX_FWD + `SWL_GROUP_LEN) begin
			region_of = swl_cfg_pkg::RG_FWD;
		end
	endfunction

	// Maps a forwarding word slot to the link it serves: C, D, A, B, G, H, E, F.
	// The mapping is its own inverse, so it also finds the slot of a link.
	function automatic logic [2:0] fwd_link_of(input logic [2:0] slot);
		fwd_link_of = {slot[2], ~slot[1], slot[0]};
	endfunction

	// Builds a status word shared by both link kinds.
	function automatic logic [31:0] status_word(input logic [1:0] kind, input logic [7:0] dest,
			input logic junk, input logic duse, input logic suse, input logic [1:0] net);
		status_word = 32'h0000_0000;
		status_word[`SWL_ST_KIND] = kind;
		status_word[`SWL_ST_DEST] = (duse | suse) ? dest : 8'h00;
		status_word[`SWL_ST_NET] = net;
		status_word[`SWL_ST_JUNK] = junk;
		status_word[`SWL_ST_DST_USE] = duse;
		status_word[`SWL_ST_SRC_USE] = suse;
	endfunction

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	logic [`SWL_IDX_W-1:0] idx;
	logic [2:0] sub;
	logic mapped;
	swl_cfg_pkg::swl_region_t region;
	logic wr_acc;
	logic [31:0] rd_mux;
	logic [1:0] dbg_cfg_r [2];
	logic [4:0] origin_r;
	logic [NLINK-1:0] err_r;
	logic [NLINK-1:0] issued_r;
	logic [NLINK-1:0] credit_r;
	logic [`SWL_GAP_W-1:0] symgap_r [NLINK];
	logic [`SWL_GAP_W-1:0] tokgap_r [NLINK];

	// Word index and the link offset within a replicated group.
	assign idx = paddr_in[`SWL_IDX_W+1:2];
	assign sub = idx[2:0];
	assign region = region_of(idx);
	assign mapped = (region != swl_cfg_pkg::RG_NONE) && (paddr_in[11:`SWL_IDX_W+2] == 2'h0);
	// A write lands only at the edge where the master sees pready high.
	assign wr_acc = psel_in & penable_in & pready_out & pwrite_in & mapped;

	// Read data multiplexer; reserved and write-only bits read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (region)
			swl_cfg_pkg::RG_DBG0: begin
				rd_mux[1:0] = dbg_cfg_r[0];
			end
			swl_cfg_pkg::RG_DBG1: begin
				rd_mux[1:0] = dbg_cfg_r[1];
			end
			swl_cfg_pkg::RG_ORIGIN: begin
				rd_mux[4:0] = origin_r;
			end
			swl_cfg_pkg::RG_LSTAT: begin
				rd_mux = status_word(link_kind_in[sub], link_dest_in[sub], link_junk_in[sub],
					link_dst_use_in[sub], link_src_use_in[sub], link_net_out[sub]);
				rd_mux[`SWL_ST_DIR] = link_dir_out[sub];
			end
			swl_cfg_pkg::RG_PSTAT: begin
				rd_mux = status_word(processor_link_kind_in[sub], processor_link_dest_in[sub], processor_link_junk_in[sub],
					processor_link_dst_use_in[sub], processor_link_src_use_in[sub], processor_link_net_out[sub]);
			end
			swl_cfg_pkg::RG_LCFG: begin
				rd_mux[`SWL_CF_EN] = link_enable_out[sub];
				rd_mux[`SWL_CF_WIDE] = link_wide_out[sub];
				rd_mux[`SWL_CF_ERR] = err_r[sub];
				rd_mux[`SWL_CF_ISSUED] = issued_r[sub];
				rd_mux[`SWL_CF_CREDIT] = credit_r[sub];
				rd_mux[`SWL_CF_SYMGAP] = symgap_r[sub];
				rd_mux[`SWL_CF_TOKGAP] = tokgap_r[sub];
			end
			swl_cfg_pkg::RG_FWD: begin
				rd_mux[`SWL_FW_EN] = fwd_enable_out[fwd_link_of(sub)];
				rd_mux[`SWL_FW_PROC] = fwd_proc_out[fwd_link_of(sub)];
				rd_mux[`SWL_FW_CHAN] = fwd_chan_out[fwd_link_of(sub)];
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle, with data and error.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else if (psel_in & penable_in & ~pready_out) begin
			pready_out <= 1'b1;
			prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
			pslverr_out <= ~mapped;
		end else begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Shared halt line
	// ------------------------------------------------------------------------
	logic [2:0] pin_sync_r;
	logic pin_halt_r;
	logic [1:0] core_drive;
	logic halt_nxt;
	logic halt_rise;

	// External debug pin: three flip-flops, a change counts when stages two and three agree.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_sync_r <= 3'h7;
			pin_halt_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], ext_halt_pin_n_in};
			if (pin_sync_r[1] == pin_sync_r[2]) begin
				pin_halt_r <= ~pin_sync_r[2];
			end
		end
	end

	// Each halted core drives the line only when its tile allows it.
	assign core_drive[0] = core_halted_flag_in[0] & dbg_cfg_r[0][`SWL_DBG_DRIVE_EN];
	assign core_drive[1] = core_halted_flag_in[1] & dbg_cfg_r[1][`SWL_DBG_DRIVE_EN];
	assign halt_nxt = pin_halt_r | core_drive[0] | core_drive[1];
	assign halt_rise = halt_nxt & ~shared_halt_line_out;

	// Line and per-core debug requests, registered.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shared_halt_line_out <= 1'b0;
			core_debug_req_out <= 2'h0;
		end else begin
			shared_halt_line_out <= halt_nxt;
			core_debug_req_out[0] <= halt_nxt & dbg_cfg_r[0][`SWL_DBG_REQ_EN];
			core_debug_req_out[1] <= halt_nxt & dbg_cfg_r[1][`SWL_DBG_REQ_EN];
		end
	end

	// Tile debug line controls, reset to zero.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			dbg_cfg_r[0] <= 2'h0;
			dbg_cfg_r[1] <= 2'h0;
		end else if (wr_acc && region == swl_cfg_pkg::RG_DBG0) begin
			dbg_cfg_r[0] <= pwdata_in[1:0];
		end else if (wr_acc && region == swl_cfg_pkg::RG_DBG1) begin
			dbg_cfg_r[1] <= pwdata_in[1:0];
		end
	end

	// Origin record: a new halt event overrides a software write in the same cycle.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			origin_r <= 5'h00;
		end else if (halt_rise) begin
			origin_r <= 5'h00;
			origin_r[`SWL_ORIG_PIN] <= pin_halt_r;
			origin_r[`SWL_ORIG_CORE1] <= core_drive[1];
			origin_r[`SWL_ORIG_CORE0] <= core_drive[0];
		end else if (wr_acc && region == swl_cfg_pkg::RG_ORIGIN) begin
			origin_r <= {pwdata_in[`SWL_ORIG_PIN], 2'h0, pwdata_in[`SWL_ORIG_CORE1], pwdata_in[`SWL_ORIG_CORE0]};
		end
	end

	// ------------------------------------------------------------------------
	// Per-link registers
	// ------------------------------------------------------------------------
	logic [11:0] idle_r [NLINK];
	logic [NLINK-1:0] tok_end_r;
	logic [NLINK-1:0] credit_request_token_wr;
	logic [NLINK-1:0] rxrst_wr;
	logic [NLINK-1:0] credit_nxt;
	logic [NLINK-1:0] enable_nxt;
	logic [11:0] idle_nxt [NLINK];
	logic [11:0] need [NLINK];

	// Write-one command strobes and next-state terms per external link.
	always_comb begin
		for (int i = 0; i < NLINK; i++) begin
			credit_request_token_wr[i] = wr_acc && region == swl_cfg_pkg::RG_LCFG && sub == 3'(i) && pwdata_in[`SWL_CF_CREDIT_REQUEST_TOKEN];
			rxrst_wr[i] = wr_acc && region == swl_cfg_pkg::RG_LCFG && sub == 3'(i) && pwdata_in[`SWL_CF_RXRST];
			enable_nxt[i] = (wr_acc && region == swl_cfg_pkg::RG_LCFG && sub == 3'(i)) ?
				pwdata_in[`SWL_CF_EN] : link_enable_out[i];
			// Arriving credit wins over a clear in the same cycle.
			credit_nxt[i] = credit_rx_in[i] | (credit_r[i] & ~credit_request_token_wr[i]);
			idle_nxt[i] = tx_symbol_in[i] ? 12'h000 :
				(idle_r[i] == `SWL_IDLE_MAX ? idle_r[i] : idle_r[i] + 12'h001);
			need[i] = {1'b0, ((tx_symbol_in[i] ? tx_token_end_in[i] : tok_end_r[i]) ?
				tokgap_r[i] : symgap_r[i])};
		end
	end

	// Direction and network fields, writable, reset zero, driven out directly.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			link_dir_out <= '0;
			link_net_out <= '0;
			processor_link_net_out <= '0;
		end else if (wr_acc && region == swl_cfg_pkg::RG_LSTAT) begin
			link_dir_out[sub] <= pwdata_in[`SWL_ST_DIR];
			link_net_out[sub] <= pwdata_in[`SWL_ST_NET];
		end else if (wr_acc && region == swl_cfg_pkg::RG_PSTAT) begin
			processor_link_net_out[sub] <= pwdata_in[`SWL_ST_NET];
		end
	end

	// Link enable, width and spacing fields.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			link_enable_out <= '0;
			link_wide_out <= '0;
			for (int i = 0; i < NLINK; i++) begin
				symgap_r[i] <= 11'h000;
				tokgap_r[i] <= 11'h000;
			end
		end else begin
			link_enable_out <= enable_nxt;
			if (wr_acc && region == swl_cfg_pkg::RG_LCFG) begin
				link_wide_out[sub] <= pwdata_in[`SWL_CF_WIDE];
				symgap_r[sub] <= pwdata_in[`SWL_CF_SYMGAP];
				tokgap_r[sub] <= pwdata_in[`SWL_CF_TOKGAP];
			end
		end
	end

	// Credit, error and command pulses; an event beats a clear in the same cycle.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			err_r <= '0;
			issued_r <= '0;
			credit_r <= '0;
			credit_request_token_out <= '0;
			rx_reset_out <= '0;
		end else begin
			credit_r <= credit_nxt;
			credit_request_token_out <= credit_request_token_wr;
			rx_reset_out <= rxrst_wr;
			for (int i = 0; i < NLINK; i++) begin
				err_r[i] <= rx_error_in[i] | (err_r[i] & ~rxrst_wr[i]);
				issued_r[i] <= credit_issued_in[i] | (issued_r[i] & ~rxrst_wr[i]);
			end
		end
	end

	// Transmit spacing: idle cycles since the last symbol must exceed the gap field.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_ready_out <= '0;
			tok_end_r <= '0;
			for (int i = 0; i < NLINK; i++) begin
				idle_r[i] <= `SWL_IDLE_MAX;
			end
		end else begin
			for (int i = 0; i < NLINK; i++) begin
				idle_r[i] <= idle_nxt[i];
				if (tx_symbol_in[i]) begin
					tok_end_r[i] <= tx_token_end_in[i];
				end
				// No sending without credit or while disabled.
				tx_ready_out[i] <= enable_nxt[i] & credit_nxt[i] & (idle_nxt[i] > need[i]);
			end
		end
	end

	// ------------------------------------------------------------------------
	// Fixed forwarding
	// ------------------------------------------------------------------------

	// Forwarding fields, held by link number through the slot order, reset disabled.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fwd_enable_out <= '0;
			fwd_proc_out <= '0;
			fwd_chan_out <= '0;
		end else if (wr_acc && region == swl_cfg_pkg::RG_FWD) begin
			fwd_enable_out[fwd_link_of(sub)] <= pwdata_in[`SWL_FW_EN];
			fwd_proc_out[fwd_link_of(sub)] <= pwdata_in[`SWL_FW_PROC];
			fwd_chan_out[fwd_link_of(sub)] <= pwdata_in[`SWL_FW_CHAN];
		end
	end

endmodule // swl_cfg
`default_nettype wire

/* File: verilog/swl_cfg_defines.svh */
// Register indices, field positions and reset values of the switch link configuration block.
`ifndef SWL_CFG_DEFINES_SVH
`define SWL_CFG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SWL_IDX_W 8
`define SWL_IDX_DBG0 8'h10
`define SWL_IDX_DBG1 8'h11
`define SWL_IDX_ORIGIN 8'h1f
`define SWL_IDX_LSTAT 8'h20
`define SWL_IDX_PSTAT 8'h40
`define SWL_IDX_LCFG 8'h80
`define SWL_IDX_FWD 8'ha0
`define SWL_GROUP_LEN 8'h08

// ----------------------------------------------------------------------------
// Debug line fields
// ----------------------------------------------------------------------------
`define SWL_DBG_REQ_EN 1
`define SWL_DBG_DRIVE_EN 0
`define SWL_ORIG_PIN 4
`define SWL_ORIG_CORE1 1
`define SWL_ORIG_CORE0 0

// ----------------------------------------------------------------------------
// Link status fields
// ----------------------------------------------------------------------------
`define SWL_ST_KIND 25:24
`define SWL_ST_DEST 23:16
`define SWL_ST_DIR 11:8
`define SWL_ST_NET 5:4
`define SWL_ST_JUNK 2
`define SWL_ST_DST_USE 1
`define SWL_ST_SRC_USE 0

// ----------------------------------------------------------------------------
// External link setup fields
// ----------------------------------------------------------------------------
`define SWL_CF_EN 31
`define SWL_CF_WIDE 30
`define SWL_CF_ERR 27
`define SWL_CF_ISSUED 26
`define SWL_CF_CREDIT 25
`define SWL_CF_CREDIT_REQUEST_TOKEN 24
`define SWL_CF_RXRST 23
`define SWL_CF_SYMGAP 21:11
`define SWL_CF_TOKGAP 10:0
`define SWL_GAP_W 11
`define SWL_IDLE_MAX 12'hfff

// ----------------------------------------------------------------------------
// Fixed forwarding fields
// ----------------------------------------------------------------------------
`define SWL_FW_EN 31
`define SWL_FW_PROC 8
`define SWL_FW_CHAN 4:0

`endif

/* File: verilog/swl_cfg_pkg.sv */
// Types shared by the switch link configuration block.
`default_nettype none
package swl_cfg_pkg;
	// Register group selected by an APB address.
	typedef enum logic [2:0] {
		RG_NONE,
		RG_DBG0,
		RG_DBG1,
		RG_ORIGIN,
		RG_LSTAT,
		RG_PSTAT,
		RG_LCFG,
		RG_FWD
	} swl_region_t;
endpackage
`default_nettype wire

/* File: testbench/swl_cfg_assertions.sv */
// Port checker of the switch link configuration block.
`timescale 1ns/1ps
`default_nettype none
module swl_cfg_assertions #(
	parameter int NLINK = 8
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic shared_halt_line_out,
	input wire logic [1:0] core_debug_req_out,
	input wire logic [NLINK-1:0] credit_request_token_out,
	input wire logic [NLINK-1:0] rx_reset_out,
	input wire logic [NLINK-1:0] tx_ready_out,
	input wire logic [NLINK-1:0] tx_symbol_in,
	input wire logic [NLINK-1:0] link_enable_out
);
	// All checks run on the switch clock and rest while reset is high.
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	apb_wait_state_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("access not answered in time");
	apb_answer_cause_a: assert property (pready_out |-> psel_in && penable_in)
		else $error("answer without an access phase");
	apb_single_ready_a: assert property (pready_out |=> !pready_out)
		else $error("answer held too long");
	idle_data_zero_a: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside answer");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error flag without an answer");
	token_one_cycle_a: assert property (|credit_request_token_out |=>
		(credit_request_token_out & $past(credit_request_token_out)) == '0) else $error("credit request too long");
	rx_reset_pulse_a: assert property (|rx_reset_out |=> (rx_reset_out & $past(rx_reset_out)) == '0)
		else $error("receiver reset too long");
	ready_needs_enable_a: assert property ((tx_ready_out & ~link_enable_out & ~$past(link_enable_out)) == '0)
		else $error("transmit ready on a disabled link");
	gap_after_symbol_a: assert property ((tx_ready_out & $past(tx_symbol_in)) == '0)
		else $error("ready right after a symbol");
	req_needs_line_a: assert property (core_debug_req_out != 2'h0 |-> shared_halt_line_out)
		else $error("debug request without halt line");
	// Main scenarios.
	cover property (pslverr_out);
	cover property ($rose(shared_halt_line_out));
	cover property (|credit_request_token_out);
endmodule // swl_cfg_assertions
`default_nettype wire

/* File: testbench/swl_cfg_far_node.sv */
// Behavioural far node of the external links: credit answers, symbols and receive errors.
`timescale 1ns/1ps
`default_nettype none
module swl_cfg_far_node #(
	parameter int NLINK = 8
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic slow_in,
	input wire logic [NLINK-1:0] go_in,
	input wire logic [NLINK-1:0] end_in,
	input wire logic [NLINK-1:0] err_in,
	input wire logic [NLINK-1:0] token_in,
	input wire logic [NLINK-1:0] ready_in,
	output logic [NLINK-1:0] credit_out,
	output logic [NLINK-1:0] issued_out,
	output logic [NLINK-1:0] symbol_out,
	output logic [NLINK-1:0] token_end_out,
	output logic [NLINK-1:0] error_out
);
	logic [4:0][NLINK-1:0] wait_r;
	// A credit request is answered with credit after two or six cycles.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wait_r <= '0;
			credit_out <= '0;
			issued_out <= '0;
		end else begin
			wait_r <= {wait_r[3:0], token_in};
			credit_out <= slow_in ? wait_r[4] : wait_r[0];
			issued_out <= wait_r[1];
		end
	end
	// Symbols leave only while the link may send, never in two cycles in a row.
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			symbol_out <= '0;
			token_end_out <= '0;
			error_out <= '0;
		end else begin
			symbol_out <= go_in & ready_in & ~symbol_out;
			token_end_out <= go_in & ready_in & ~symbol_out & end_in;
			error_out <= err_in;
		end
	end
endmodule // swl_cfg_far_node
`default_nettype wire

/* File: testbench/swl_cfg_test.sv */
// Self-checking bench of the switch link configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end end
module swl_cfg_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pw = 1'b0;
	logic [11:0] pa = 12'h0;
	logic [31:0] pd = 32'h0;
	logic pin_n = 1'b1;
	logic [1:0] flags = 2'h0;
	logic slow = 1'b0;
	logic [7:0][1:0] kind = '0;
	logic [7:0][7:0] dest = '0;
	logic [7:0] junk = 8'h0, du = 8'h0, su = 8'h0, go = 8'h0, endt = 8'h0, errc = 8'h0;
	logic [7:0][3:0] dir;
	logic [7:0][1:0] net, pnet;
	logic [7:0][4:0] fch;
	logic [7:0] err, iss, cr, sym, tend, en, wide, tok, rxr, rdy, fen, fpr;
	logic [31:0] prd, q, d;
	logic [11:0] a;
	logic [10:0] g1, g2;
	logic rdyo, serr, se, line;
	logic [1:0] req;
	int seed = 32'h6099, fails = 0, samples_checked = 0, cyc = 0, k;
	always #2 clk = ~clk;
	swl_cfg #(.NLINK(8)) i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(rdyo), .pslverr_out(serr),
		.ext_halt_pin_n_in(pin_n), .core_halted_flag_in(flags), .shared_halt_line_out(line),
		.core_debug_req_out(req), .link_kind_in(kind), .link_dest_in(dest), .link_junk_in(junk),
		.link_dst_use_in(du), .link_src_use_in(su), .link_dir_out(dir), .link_net_out(net),
		.processor_link_kind_in(kind), .processor_link_dest_in(dest), .processor_link_junk_in(junk), .processor_link_dst_use_in(du),
		.processor_link_src_use_in(su), .processor_link_net_out(pnet), .rx_error_in(err), .credit_issued_in(iss),
		.credit_rx_in(cr), .tx_symbol_in(sym), .tx_token_end_in(tend), .link_enable_out(en),
		.link_wide_out(wide), .credit_request_token_out(tok), .rx_reset_out(rxr), .tx_ready_out(rdy),
		.fwd_enable_out(fen), .fwd_proc_out(fpr), .fwd_chan_out(fch));
	swl_cfg_far_node #(.NLINK(8)) i_far (.sys_clk_in(clk), .sys_rst_in(rst), .slow_in(slow), .go_in(go),
		.end_in(endt), .err_in(errc), .token_in(tok), .ready_in(rdy), .credit_out(cr), .issued_out(iss),
		.symbol_out(sym), .token_end_out(tend), .error_out(err));
	// Expected status word of link n after w was written to it.
	function automatic logic [31:0] st(int n, logic [31:0] w, logic hasdir);
		return {6'h0, kind[n], (du[n] | su[n]) ? dest[n] : 8'h0, 4'h0, hasdir ? w[11:8] : 4'h0, 2'h0, w[5:4],
			1'b0, junk[n], du[n], su[n]};
	endfunction
	// One APB transfer; read data and error flag are taken at the answer edge.
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= ad;
		pd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdyo !== 1'b1 && n < 20);
		q = prd;
		se = serr;
		if (rdyo !== 1'b1) fails++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
	end
	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			apb(0, i < 2 ? 12'h40 + 12'(4 * i) : i < 5 ? 12'h80 << (i - 2) : 12'h280, 32'h0);
			`CHK(q, 32'h0)
		end
		apb(1, 12'hc40, 32'hffffffff);
		`CHK(se, 1'b1)
		apb(0, 12'ha0, 32'h0);
		`CHK({se, q}, 33'h100000000)
		apb(0, 12'h40, 32'h0);
		`CHK(q, 32'h0)
		$display("reset test done");
		kind <= 16'($random(seed));
		dest <= {$random(seed), $random(seed)};
		junk <= 8'($random(seed));
		du <= 8'($random(seed)) & 8'h7f;
		su <= 8'($random(seed)) & 8'h7f;
		for (int n = 0; n < 8; n++) begin
			d = $random(seed);
			apb(1, 12'h80 + 12'(4 * n), d);
			apb(0, 12'h80 + 12'(4 * n), 32'h0);
			`CHK(q, st(n, d, 1'b1))
			apb(1, 12'h100 + 12'(4 * n), d);
			apb(0, 12'h100 + 12'(4 * n), 32'h0);
			`CHK(q, st(n, d, 1'b0))
			`CHK({dir[n], net[n], pnet[n]}, {d[11:8], d[5:4], d[5:4]})
		end
		$display("status test done");
		for (int s = 0; s < 8; s++) begin
			d = $random(seed);
			apb(1, 12'h280 + 12'(4 * s), d);
			repeat (3) @(posedge clk);
			`CHK({fen[s ^ 2], fpr[s ^ 2], fch[s ^ 2]}, {d[31], d[8], d[4:0]})
			apb(0, 12'h280 + 12'(4 * s), 32'h0);
			`CHK(q, d & 32'h8000011f)
		end
		$display("forwarding test done");
		for (int n = 0; n < 8; n++) begin
			a = 12'h200 + 12'(4 * n);
			g1 = n == 7 ? 11'h0 : 11'($random(seed)) & 11'h7;
			g2 = 11'($random(seed)) & 11'h7;
			d = {1'b1, 1'($random(seed)), 5'h0, 1'b1, 2'h0, g1, g2};
			slow <= n[0];
			apb(1, a, d);
			repeat (8) @(posedge clk);
			apb(0, a, 32'h0);
			`CHK(q & 32'hcfbfffff, (d & 32'hc03fffff) | 32'h06000000)
			`CHK({en[n], wide[n]}, d[31:30])
			go[n] <= 1'b1;
			for (int e = 0; e < 2; e++) begin
				endt[n] <= e[0];
				k = 0;
				do begin
					@(posedge clk);
					k++;
				end while (!(sym[n] === 1'b1 && tend[n] === e[0]) && k < 60);
				k = 0;
				@(posedge clk);
				while (rdy[n] !== 1'b1 && k < 60) begin
					k++;
					@(posedge clk);
				end
				`CHK(k, (e ? g2 : g1) + 1)
			end
			go[n] <= 1'b0;
			errc[n] <= 1'b1;
			slow <= 1'b1;
			@(posedge clk);
			errc[n] <= 1'b0;
			apb(0, a, 32'h0);
			`CHK(q[27], 1'b1)
			apb(1, a, (d & 32'hfeffffff) | 32'h00800000);
			@(posedge clk);
			`CHK({rxr[n], tok[n]}, 2'h2)
			apb(0, a, 32'h0);
			`CHK(q & 32'h0e000000, 32'h02000000)
			apb(1, a, d);
			@(posedge clk);
			`CHK(tok[n], 1'b1)
			apb(0, a, 32'h0);
			`CHK(q[25], 1'b0)
			repeat (10) @(posedge clk);
			apb(0, a, 32'h0);
			`CHK(q[25], 1'b1)
		end
		$display("link test done");
		for (int t = 0; t < 2; t++) begin
			apb(1, 12'h40 + 12'(4 * t), 32'h3);
			apb(1, 12'h44 - 12'(4 * t), 32'h2);
			flags <= 2'h3;
			repeat (3) @(posedge clk);
			`CHK({line, req}, 3'h7)
			apb(0, 12'h7c, 32'h0);
			`CHK(q, 32'h1 << t)
			flags <= 2'h2 >> t;
			repeat (3) @(posedge clk);
			`CHK({line, req}, 3'h0)
			flags <= 2'h0;
		end
		pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK({line, req}, 3'h7)
		apb(0, 12'h7c, 32'h0);
		`CHK(q, 32'h10)
		pin_n <= 1'b1;
		$display("halt test done");
		wrap_up();
	end
endmodule // swl_cfg_test
bind swl_cfg swl_cfg_assertions #(.NLINK(NLINK)) i_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .shared_halt_line_out(shared_halt_line_out), .core_debug_req_out(core_debug_req_out),
	.credit_request_token_out(credit_request_token_out), .rx_reset_out(rx_reset_out), .tx_ready_out(tx_ready_out),
	.tx_symbol_in(tx_symbol_in), .link_enable_out(link_enable_out));
`default_nettype wire
